/* src/fsw_regs.vh */
`ifndef FSW_REGS_VH
`define FSW_REGS_VH
// Instruction codes
`define FSW_CMD_RD_SR1 8'h05
`define FSW_CMD_RD_SR2 8'h35
`define FSW_CMD_RD_SR3 8'h15
`define FSW_CMD_WR_SR1 8'h01
`define FSW_CMD_WR_SR2 8'h31
`define FSW_CMD_WR_SR3 8'h11
`define FSW_CMD_SUSPEND 8'h75
`define FSW_CMD_RESUME 8'h7A
`define FSW_CMD_UNIT_LOCK 8'h36
`define FSW_CMD_UNIT_UNLOCK 8'h39
// First status byte fields
`define FSW_SR1_RANGE_LO 2
`define FSW_SR1_BOTTOM 5
`define FSW_SR1_SMALL 6
// Second status byte fields
`define FSW_SR2_QUAD 1
`define FSW_SR2_OTP_LO 3
`define FSW_SR2_COMPL 6
`define FSW_SR2_SUSPEND 7
// Third status byte fields
`define FSW_SR3_SCHEME 2
`define FSW_SR3_DRV_LO 5
// Reset values
`define FSW_DRV_RESET 2'h3
`define FSW_LOCK_RESET 62'h3FFFFFFFFFFFFFFF
// Array geometry
`define FSW_ARRAY_TOP 21'h1FFFFF
`define FSW_BLOCK_SIZE 21'h010000
`define FSW_SECTOR_SIZE 21'h001000
`define FSW_TOP_BLOCK_BASE 21'h1F0000
`define FSW_UNITS 62
`define FSW_LOW_SECTORS 16
`define FSW_MID_BLOCKS 30
`define FSW_ADDR_BYTES 3'h4
`endif

/* src/fsw_status_protect.v */
// Contract
// RULE1 - Suspend instruction sets suspend flag
// RULE2 - Resume or power cycle clears suspend
// RULE3 - Security lock bits reset to zero
// RULE4 - Lock bits set individually, never clear
// RULE5 - Quad off: pause pin, standard/dual only
// RULE6 - Quad on: IO2/IO3, no pause
// RULE7 - Scheme zero uses range fields
// RULE8 - Scheme one uses unit lock bits
// RULE9 - Unit lock bits reset to one
// RULE10 - Drive strength codes, default quarter
// RULE11 - Reserved bits read zero, writes ignored
// RULE12 - Block ranges from top or bottom
// RULE13 - Code zero none, 11x whole array
// RULE14 - Sector ranges 4KB to 32KB
// RULE15 - Overlapping erase/program ignored entirely
// RULE16 - Complement inverts protected area
// RULE17 - Locked unit rejects erase/program
// RULE18 - Compare request start/end with range
`include "fsw_regs.vh"
module fsw_status_protect (
  input wire clk,
  input wire rst_b,
  input wire spiCsB,
  input wire spiSclk,
  input wire spiMosi,
  output reg spiMiso,
  output reg spiMisoOe,
  input wire opValid,
  input wire [20:0] opStart,
  input wire [20:0] opEnd,
  output reg opGrant,
  output reg opDeny,
  output reg quadMode,
  output reg pauseEnable,
  output reg [1:0] driveStrength,
  output reg [2:0] otpLocks,
  output reg suspended
);
  reg [1:0] csSync, sckSync, mosiSync;
  reg sckPrev;
  reg [2:0] bitCnt_q, byteCnt_q;
  reg [7:0] shift_q, cmd_q, tx_q;
  reg [23:0] addr_q;
  reg [2:0] rangeCode_q;
  reg bottom_q, small_q, compl_q, quad_q, scheme_q, sus_q;
  reg [2:0] otp_q;
  reg [1:0] drv_q;
  reg [61:0] unitLock_q;
  wire csActive = ~csSync[1];
  wire sckRise = csActive & sckSync[1] & ~sckPrev;
  wire sckFall = csActive & ~sckSync[1] & sckPrev;
  wire [7:0] rxByte = {shift_q[6:0], mosiSync[1]};
  wire byteDone = sckRise & (bitCnt_q == 3'h7);
  wire isRead = (cmd_q == `FSW_CMD_RD_SR1) | (cmd_q == `FSW_CMD_RD_SR2) |
    (cmd_q == `FSW_CMD_RD_SR3);
  // RULE11 reserved read zero
  wire [7:0] sr1 = {1'b0, small_q, bottom_q, rangeCode_q, 2'h0};
  wire [7:0] sr2 = {sus_q, compl_q, otp_q, 1'b0, quad_q, 1'b0};
  wire [7:0] sr3 = {1'b0, drv_q, 2'h0, scheme_q, 2'h0};
  reg [7:0] rdVal;
  always @* begin
    case (rxByte)
      `FSW_CMD_RD_SR1: rdVal = sr1;
      `FSW_CMD_RD_SR2: rdVal = sr2;
      `FSW_CMD_RD_SR3: rdVal = sr3;
      default: rdVal = 8'h00;
    endcase
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csSync <= 2'h3;
      sckSync <= 2'h0;
      mosiSync <= 2'h0;
      sckPrev <= 1'b0;
    end else begin
      csSync <= {csSync[0], spiCsB};
      sckSync <= {sckSync[0], spiSclk};
      mosiSync <= {mosiSync[0], spiMosi};
      sckPrev <= sckSync[1];
    end
  end
  // Unit address of lock commands
  reg [5:0] unitIdx;
  always @* begin
    if (addr_q[20:16] == 5'h00) begin
      unitIdx = {2'h0, addr_q[15:12]};
    end else if (addr_q[20:16] == 5'h1F) begin
      unitIdx = 6'd46 + {2'h0, addr_q[15:12]};
    end else begin
      unitIdx = 6'd15 + {1'b0, addr_q[20:16]};
    end
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_q <= 3'h0;
      byteCnt_q <= 3'h0;
      shift_q <= 8'h00;
      cmd_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 24'h000000;
      rangeCode_q <= 3'h0;
      bottom_q <= 1'b0;
      small_q <= 1'b0;
      compl_q <= 1'b0;
      quad_q <= 1'b0;
      scheme_q <= 1'b0;
      // RULE2 cleared by power cycle
      sus_q <= 1'b0;
      // RULE3 locks default zero
      otp_q <= 3'h0;
      // RULE10 default quarter strength
      drv_q <= `FSW_DRV_RESET;
      // RULE9 all units locked
      unitLock_q <= `FSW_LOCK_RESET;
      spiMiso <= 1'b0;
      spiMisoOe <= 1'b0;
    end else if (!csActive) begin
      bitCnt_q <= 3'h0;
      byteCnt_q <= 3'h0;
      spiMisoOe <= 1'b0;
      // Lock commands complete on deselect after full address
      if (byteCnt_q == `FSW_ADDR_BYTES && bitCnt_q == 3'h0) begin
        if (cmd_q == `FSW_CMD_UNIT_LOCK) begin
          unitLock_q[unitIdx] <= 1'b1;
        end else if (cmd_q == `FSW_CMD_UNIT_UNLOCK) begin
          unitLock_q[unitIdx] <= 1'b0;
        end
      end
      cmd_q <= 8'h00;
    end else begin
      if (sckRise) begin
        shift_q <= rxByte;
        bitCnt_q <= bitCnt_q + 3'h1;
      end
      if (byteDone) begin
        if (byteCnt_q != `FSW_ADDR_BYTES) begin
          byteCnt_q <= byteCnt_q + 3'h1;
        end
        if (byteCnt_q == 3'h0) begin
          cmd_q <= rxByte;
          tx_q <= rdVal;
          // RULE1 suspend sets flag
          if (rxByte == `FSW_CMD_SUSPEND) begin
            sus_q <= 1'b1;
          end
          // RULE2 resume clears flag
          if (rxByte == `FSW_CMD_RESUME) begin
            sus_q <= 1'b0;
          end
        end else if (byteCnt_q == 3'h1) begin
          addr_q[23:16] <= rxByte;
          if (cmd_q == `FSW_CMD_WR_SR1) begin
            rangeCode_q <= rxByte[`FSW_SR1_RANGE_LO +: 3];
            bottom_q <= rxByte[`FSW_SR1_BOTTOM];
            small_q <= rxByte[`FSW_SR1_SMALL];
          end
          if (cmd_q == `FSW_CMD_WR_SR2) begin
            compl_q <= rxByte[`FSW_SR2_COMPL];
            quad_q <= rxByte[`FSW_SR2_QUAD];
            // RULE4 one-way lock bits
            otp_q <= otp_q | rxByte[`FSW_SR2_OTP_LO +: 3];
          end
          if (cmd_q == `FSW_CMD_WR_SR3) begin
            scheme_q <= rxByte[`FSW_SR3_SCHEME];
            drv_q <= rxByte[`FSW_SR3_DRV_LO +: 2];
          end
        end else if (byteCnt_q == 3'h2) begin
          addr_q[15:8] <= rxByte;
        end else if (byteCnt_q == 3'h3) begin
          addr_q[7:0] <= rxByte;
        end
        if (byteCnt_q != 3'h0 && isRead) begin
          tx_q <= cmd_q == `FSW_CMD_RD_SR1 ? sr1 :
            cmd_q == `FSW_CMD_RD_SR2 ? sr2 : sr3;
        end
      end
      if (sckFall && isRead) begin
        spiMiso <= tx_q[7];
        spiMisoOe <= 1'b1;
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end
  // RULE12 block range size
  // RULE13 none or whole array
  // RULE14 sector range size
  reg rangeAny, rangeAll;
  reg [20:0] rangeSize, rangeLo, rangeHi;
  always @* begin
    rangeAny = rangeCode_q != 3'h0;
    rangeAll = rangeCode_q[2:1] == 2'h3;
    rangeSize = `FSW_BLOCK_SIZE;
    if (small_q) begin
      rangeSize = rangeCode_q[2] ? (`FSW_SECTOR_SIZE << 3) :
        (`FSW_SECTOR_SIZE << (rangeCode_q[1:0] - 2'h1));
    end else begin
      rangeSize = `FSW_BLOCK_SIZE << (rangeCode_q - 3'h1);
    end
    if (rangeAll) begin
      rangeLo = 21'h000000;
      rangeHi = `FSW_ARRAY_TOP;
    end else if (bottom_q) begin
      rangeLo = 21'h000000;
      rangeHi = rangeSize - 21'h000001;
    end else begin
      rangeLo = `FSW_ARRAY_TOP - rangeSize + 21'h000001;
      rangeHi = `FSW_ARRAY_TOP;
    end
  end
  // RULE17 locked unit overlap
  reg lockHit;
  reg [20:0] uLo, uHi;
  integer i;
  always @* begin
    lockHit = 1'b0;
    uLo = 21'h000000;
    uHi = 21'h000000;
    for (i = 0; i < `FSW_UNITS; i = i + 1) begin
      if (i < `FSW_LOW_SECTORS) begin
        uLo = `FSW_SECTOR_SIZE * i[20:0];
        uHi = uLo + `FSW_SECTOR_SIZE - 21'h000001;
      end else if (i < `FSW_LOW_SECTORS + `FSW_MID_BLOCKS) begin
        uLo = `FSW_BLOCK_SIZE * (i[20:0] - 21'd15);
        uHi = uLo + `FSW_BLOCK_SIZE - 21'h000001;
      end else begin
        uLo = `FSW_TOP_BLOCK_BASE + `FSW_SECTOR_SIZE * (i[20:0] - 21'd46);
        uHi = uLo + `FSW_SECTOR_SIZE - 21'h000001;
      end
      if (unitLock_q[i] && opStart <= uHi && opEnd >= uLo) begin
        lockHit = 1'b1;
      end
    end
  end
  // RULE18 start/end compare
  wire overlapRange = rangeAny & (opStart <= rangeHi) & (opEnd >= rangeLo);
  // RULE16 complement inverts area
  wire insideRange = rangeAny & (opStart >= rangeLo) & (opEnd <= rangeHi);
  wire rangeHit = compl_q ? ~insideRange : overlapRange;
  // RULE7 range scheme
  // RULE8 lock-bit scheme
  wire denyNow = scheme_q ? lockHit : rangeHit;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opGrant <= 1'b0;
      opDeny <= 1'b0;
      quadMode <= 1'b0;
      pauseEnable <= 1'b1;
      driveStrength <= `FSW_DRV_RESET;
      otpLocks <= 3'h0;
      suspended <= 1'b0;
    end else begin
      // RULE15 whole request refused
      opGrant <= opValid & ~denyNow;
      opDeny <= opValid & denyNow;
      // RULE5 pause pin while quad off
      pauseEnable <= ~quad_q;
      // RULE6 quad transfers enabled
      quadMode <= quad_q;
      driveStrength <= drv_q;
      otpLocks <= otp_q;
      suspended <= sus_q;
    end
  end
endmodule

/* dv/fsw_spi_host.sv */
module fsw_spi_host (
  input wire clk,
  input wire spiMiso,
  output logic spiCsB,
  output logic spiSclk,
  output logic spiMosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spiCsB = 1'b1;
    spiSclk = 1'b0;
    spiMosi = 1'b0;
  end
  // Sends nb bytes from the top of w, last byte read back
  task automatic xfer(input logic [31:0] w, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    spiCsB <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < nb * 8; i++) begin
      spiMosi <= w[31 - i];
      repeat (4) @(posedge clk);
      spiSclk <= 1'b1;
      repeat (4) @(posedge clk);
      rd = {rd[6:0], spiMiso};
      spiSclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    spiCsB <= 1'b1;
    spiMosi <= ~spiMosi;
    repeat (8) @(posedge clk);
  endtask
endmodule

/* dv/fsw_status_protect_chk.sv */
module fsw_status_protect_chk (
  input wire clk,
  input wire rst_b,
  input wire spiCsB,
  input wire spiMisoOe,
  input wire opValid,
  input wire opGrant,
  input wire opDeny,
  input wire quadMode,
  input wire pauseEnable,
  input wire [1:0] driveStrength,
  input wire [2:0] otpLocks,
  input wire suspended
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_op_answer: assert property (opValid |=> opGrant ^ opDeny)
    else $error("request not answered once");
  a_no_spurious: assert property (!opValid |=> !opGrant && !opDeny)
    else $error("answer without request");
  a_ans_excl: assert property (!(opGrant && opDeny))
    else $error("grant and deny together");
  a_resp_pulse: assert property ((opGrant || opDeny) && !opValid |=> !opGrant && !opDeny)
    else $error("answer longer than one cycle");
  a_quad_pause: assert property (pauseEnable == !quadMode)
    else $error("pause enable not inverse of quad");
  a_otp_sticky: assert property ((otpLocks & $past(otpLocks)) == $past(otpLocks))
    else $error("lock bit cleared");
  a_stat_idle: assert property (spiCsB [*6] |-> $stable({quadMode, driveStrength, otpLocks, suspended}))
    else $error("status changed while idle");
  a_stat_frame: assert property ($changed({quadMode, driveStrength, otpLocks, suspended}) |-> !$past(spiCsB, 5))
    else $error("status changed outside frame");
  a_oe_release: assert property (spiCsB [*4] |-> !spiMisoOe)
    else $error("data out driven while deselected");
  cover property ($rose(spiMisoOe));
  cover property (opGrant);
  cover property (opDeny);
  cover property ($rose(suspended));
endmodule

/* dv/fsw_status_protect_tb.sv */
module fsw_status_protect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] s2, s1; logic [20:0] a, b; logic dn;} fsw_row_t;
  logic clk = 1'b0, rst_b = 1'b0, opValid = 1'b0;
  logic [20:0] opStart = 21'h000000, opEnd = 21'h000000;
  wire spiCsB, spiSclk, spiMosi, spiMiso, spiMisoOe, opGrant, opDeny;
  wire quadMode, pauseEnable, suspended;
  wire [1:0] driveStrength;
  wire [2:0] otpLocks;
  int mismatches = 0, total_checks = 0;
  logic [7:0] rd;
  fsw_row_t rows [15] = '{
    '{8'h00, 8'h00, 21'h000000, 21'h1FFFFF, 1'h0}, '{8'h00, 8'h04, 21'h1F0000, 21'h1F0000, 1'h1},
    '{8'h00, 8'h04, 21'h1EFFFF, 21'h1F0000, 1'h1}, '{8'h00, 8'h08, 21'h1DFFFF, 21'h1DFFFF, 1'h0},
    '{8'h00, 8'h08, 21'h1E0000, 21'h1E0000, 1'h1}, '{8'h00, 8'h2C, 21'h03FFFF, 21'h03FFFF, 1'h1},
    '{8'h00, 8'h10, 21'h17FFFF, 21'h17FFFF, 1'h0}, '{8'h00, 8'h34, 21'h0FFFFF, 21'h0FFFFF, 1'h1},
    '{8'h00, 8'h78, 21'h1FFFFF, 21'h1FFFFF, 1'h1}, '{8'h00, 8'h44, 21'h1FF000, 21'h1FF000, 1'h1},
    '{8'h00, 8'h44, 21'h1FEFFF, 21'h1FEFFF, 1'h0}, '{8'h00, 8'h74, 21'h007FFF, 21'h007FFF, 1'h1},
    '{8'h00, 8'h74, 21'h008000, 21'h008000, 1'h0}, '{8'h40, 8'h04, 21'h1F0000, 21'h1FFFFF, 1'h0},
    '{8'h40, 8'h04, 21'h1EFFFF, 21'h1EFFFF, 1'h1}};
  always #2 clk = ~clk;
  fsw_spi_host fsw_spi_host_inst (.clk(clk), .spiMiso(spiMiso), .spiCsB(spiCsB),
    .spiSclk(spiSclk), .spiMosi(spiMosi));
  fsw_status_protect fsw_status_protect_inst (.clk(clk), .rst_b(rst_b), .spiCsB(spiCsB),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .opValid(opValid), .opStart(opStart), .opEnd(opEnd), .opGrant(opGrant), .opDeny(opDeny),
    .quadMode(quadMode), .pauseEnable(pauseEnable), .driveStrength(driveStrength),
    .otpLocks(otpLocks), .suspended(suspended));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task op(input logic [20:0] a, input logic [20:0] b, input logic e);
    logic g, d;
    g = 1'b0;
    d = 1'b0;
    opStart <= a;
    opEnd <= b;
    opValid <= 1'b1;
    repeat (2) begin
      @(posedge clk);
      opValid <= 1'b0;
      #1;
      g = g | opGrant;
      d = d | opDeny;
    end
    @(posedge clk);
    chk({6'h00, g, d}, {6'h00, ~e, e});
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk({pauseEnable, quadMode, suspended, otpLocks, driveStrength}, 8'h83);
    foreach (rows[i]) begin
      fsw_spi_host_inst.xfer({8'h01, rows[i].s1, 16'h0000}, 2, rd);
      fsw_spi_host_inst.xfer({8'h31, rows[i].s2, 16'h0000}, 2, rd);
      op(rows[i].a, rows[i].b, rows[i].dn);
    end
    fsw_spi_host_inst.xfer({8'h05, 24'h000000}, 2, rd);
    chk(rd, 8'h04);
    $display("range table done");
    fsw_spi_host_inst.xfer({8'h31, 8'h0A, 16'h0000}, 2, rd);
    chk({3'h0, otpLocks, quadMode, pauseEnable}, 8'h06);
    fsw_spi_host_inst.xfer({8'h31, 8'h10, 16'h0000}, 2, rd);
    chk({3'h0, otpLocks, quadMode, pauseEnable}, 8'h0D);
    fsw_spi_host_inst.xfer({8'h75, 24'h000000}, 1, rd);
    chk({7'h00, suspended}, 8'h01);
    fsw_spi_host_inst.xfer({8'h35, 24'h000000}, 2, rd);
    chk(rd & 8'hFA, 8'h98);
    fsw_spi_host_inst.xfer({8'h7A, 24'h000000}, 1, rd);
    chk({7'h00, suspended}, 8'h00);
    $display("second and first byte done");
    for (int d = 0; d < 4; d++) begin
      fsw_spi_host_inst.xfer({8'h11, 1'b0, d[1:0], 5'h04, 16'h0000}, 2, rd);
      chk({6'h00, driveStrength}, d[7:0]);
    end
    fsw_spi_host_inst.xfer({8'h15, 24'h000000}, 2, rd);
    chk(rd, 8'h64);
    op(21'h080000, 21'h080000, 1'h1);
    fsw_spi_host_inst.xfer({8'h39, 24'h080000}, 4, rd);
    op(21'h080000, 21'h08FFFF, 1'h0);
    op(21'h08FFFF, 21'h090000, 1'h1);
    fsw_spi_host_inst.xfer({8'h36, 24'h080000}, 4, rd);
    op(21'h080000, 21'h080000, 1'h1);
    fsw_spi_host_inst.xfer({8'h75, 24'h000000}, 1, rd);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk({pauseEnable, quadMode, suspended, otpLocks, driveStrength}, 8'h83);
    fsw_spi_host_inst.xfer({8'h11, 8'h64, 16'h0000}, 2, rd);
    op(21'h080000, 21'h080000, 1'h1);
    $display("lock scheme and reset done");
    tally_and_finish;
  end
endmodule
bind fsw_status_protect fsw_status_protect_chk fsw_status_protect_chk_inst (.clk(clk),
  .rst_b(rst_b), .spiCsB(spiCsB), .spiMisoOe(spiMisoOe), .opValid(opValid),
  .opGrant(opGrant), .opDeny(opDeny),
  .quadMode(quadMode), .pauseEnable(pauseEnable), .driveStrength(driveStrength),
  .otpLocks(otpLocks), .suspended(suspended));
